// ### logic/pdm_pkg.sv
// shared constants and types for the power-down mode controller
package pdm_pkg;
  localparam int DIV_W = 3;
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic [2:0] DIV_MAX = 3'h5;
  localparam int STS_W = 4;
  localparam logic [3:0] STS_RESET = 4'hf;
  localparam logic [3:0] STS_MIN_CODE = 4'h5;
  localparam int STOP_W = 16;
  localparam int ALL_CLOCKS_STOP_ENABLE_POS = 15;
  localparam int TIMER8_POS = 0;
  localparam logic [15:0] STOP_RESET = 16'h0fff;
  localparam logic [15:0] STOP_ALL = 16'hffff;
  localparam logic [15:0] STOP_ALL_BUT_T8 = 16'hfffe;
  localparam int IRQ_W = 16;
  localparam int CNT_W = 20;
  localparam int RESET_HOLD_CYCLES = 16;

  typedef enum logic [5:0] {
    ST_RUN = 6'h01,
    ST_SLEEP = 6'h02,
    ST_SWSTBY = 6'h04,
    ST_SETTLE = 6'h08,
    ST_ALLSTOP = 6'h10,
    ST_HWSTBY = 6'h20
  } mode_t;

  // settling wait in clock states for a settling-time code
  function automatic logic [19:0] settleStates(input logic [3:0] code);
    logic [19:0] r;
    r = 20'h00040;
    unique case (code)
      4'h5: r = 20'h00040;
      4'h6: r = 20'h00200;
      4'h7: r = 20'h00400;
      4'h8: r = 20'h00800;
      4'h9: r = 20'h01000;
      4'ha: r = 20'h04000;
      4'hb: r = 20'h08000;
      4'hc: r = 20'h10000;
      4'hd: r = 20'h20000;
      4'he: r = 20'h40000;
      4'hf: r = 20'h80000;
      default: r = 20'h00040;
    endcase
    return r;
  endfunction
endpackage

// ### logic/pdm_if.sv
// pins and wake lines between the controller and its system
`timescale 1ns/1ps
interface pdm_if;
  logic resetPin;
  logic hwStandbyPin;
  logic watchdogReset;
  logic nmi;
  logic [15:0] irq;
  logic [15:0] irqMasked;
  logic [15:0] irqDtcSource;
  logic cpuIntMasked;
  logic intEnabledPending;
  logic timer8Int;
  logic watchdogInt;
  logic [2:0] operatingModePins;
  logic ramEnableBit;
  modport dev (input resetPin, hwStandbyPin, watchdogReset, nmi, irq, irqMasked, irqDtcSource,
    cpuIntMasked, intEnabledPending, timer8Int, watchdogInt, operatingModePins, ramEnableBit);
  modport host (output resetPin, hwStandbyPin, watchdogReset, nmi, irq, irqMasked, irqDtcSource,
    cpuIntMasked, intEnabledPending, timer8Int, watchdogInt, operatingModePins, ramEnableBit);
endinterface

// ### logic/power_down_mode_controller.sv
// device end: power-down mode controller
`timescale 1ns/1ps
module power_down_mode_controller
  import pdm_pkg::*;
#(
  parameter int RESET_HOLD = RESET_HOLD_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins and wake lines
  pdm_if.dev pins,
  // cpu control writes
  input wire logic clockDivideWr,
  input wire logic [2:0] clockDivideField,
  input wire logic standbyCtrlWr,
  input wire logic standbySelectBit,
  input wire logic standbyOutputHoldBit,
  input wire logic [3:0] settlingTimeField,
  input wire logic standbyWakeEnableWr,
  input wire logic [15:0] standbyWakeEnableBit,
  input wire logic moduleStopWr,
  input wire logic [15:0] moduleStopWordIn,
  input wire logic sleepExec,
  input wire logic busBusy,
  // status and clock gating
  output logic [2:0] activeDivide,
  output logic clockEnable,
  output logic cpuHalt,
  output logic periphHalt,
  output logic oscStop,
  output logic inReset,
  output logic interruptStart,
  output logic busOutFloat,
  output logic ioFloat,
  output logic [15:0] moduleStopWord,
  output logic [14:0] moduleClockEnable,
  output logic serialStateClear,
  output logic [5:0] modeState
);
  if (RESET_HOLD < 1) begin : g_badHold
    $error("RESET_HOLD must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  mode_t mode_ff, nxt_mode;
  logic [2:0] divReq_ff, nxt_divReq, div_ff, nxt_div;
  logic selBit_ff, nxt_selBit, holdBit_ff, nxt_holdBit;
  logic [3:0] sts_ff, nxt_sts;
  logic [15:0] wakeEn_ff, nxt_wakeEn, stopReq_ff, nxt_stopReq, stop_ff, nxt_stop;
  logic [19:0] cnt_ff, nxt_cnt;
  logic [4:0] divCnt_ff, nxt_divCnt;
  logic sysReset, irqWake, intWake, allStopWake;

  assign sysReset = ~pins.resetPin | pins.watchdogReset;
  // an irq wakes only when enabled, unmasked and not a dtc source
  assign irqWake = |(pins.irq & wakeEn_ff & ~pins.irqMasked & ~pins.irqDtcSource);
  // nmi ends sleep even while the cpu masks the other interrupts
  assign intWake = pins.nmi | (pins.intEnabledPending & ~pins.cpuIntMasked);
  assign allStopWake = pins.nmi | (~pins.cpuIntMasked & (irqWake | pins.timer8Int | pins.watchdogInt));

  always_comb begin
    nxt_divReq = divReq_ff;
    nxt_selBit = selBit_ff;
    nxt_holdBit = holdBit_ff;
    nxt_sts = sts_ff;
    nxt_wakeEn = wakeEn_ff;
    nxt_stopReq = stopReq_ff;
    if (clockDivideWr && clockDivideField <= DIV_MAX) begin
      nxt_divReq = clockDivideField;
    end
    if (standbyCtrlWr) begin
      nxt_selBit = standbySelectBit;
      nxt_holdBit = standbyOutputHoldBit;
      if (settlingTimeField >= STS_MIN_CODE) begin
        nxt_sts = settlingTimeField;
      end
    end
    if (standbyWakeEnableWr) begin
      nxt_wakeEn = standbyWakeEnableBit;
    end
    if (moduleStopWr) begin
      nxt_stopReq = moduleStopWordIn;
    end
    // divide and stop settings apply only with the bus idle
    nxt_div = busBusy ? div_ff : divReq_ff;
    nxt_stop = busBusy ? stop_ff : stopReq_ff;
    if (sysReset || mode_ff == ST_HWSTBY) begin
      nxt_divReq = DIV_RESET;
      nxt_div = DIV_RESET;
      nxt_stopReq = STOP_RESET;
      nxt_stop = STOP_RESET;
      nxt_selBit = 1'b0;
      nxt_holdBit = 1'b0;
      nxt_sts = STS_RESET;
      nxt_wakeEn = 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode sequencer
  always_comb begin
    nxt_mode = mode_ff;
    nxt_cnt = cnt_ff;
    unique case (mode_ff)
      ST_RUN: begin
        if (sleepExec && !busBusy) begin
          if (selBit_ff) begin
            nxt_mode = ST_SWSTBY;
          end else if (stop_ff[ALL_CLOCKS_STOP_ENABLE_POS] && (stop_ff == STOP_ALL || stop_ff == STOP_ALL_BUT_T8)) begin
            nxt_mode = ST_ALLSTOP;
          end else begin
            nxt_mode = ST_SLEEP;
          end
        end
      end
      ST_SLEEP: begin
        if (intWake) begin
          nxt_mode = ST_RUN;
        end
      end
      ST_SWSTBY: begin
        if (pins.nmi || irqWake) begin
          nxt_mode = ST_SETTLE;
          nxt_cnt = settleStates(sts_ff) - 20'h00001;
        end
      end
      ST_SETTLE: begin
        if (cnt_ff == 20'h00000) begin
          nxt_mode = ST_RUN;
        end else begin
          nxt_cnt = cnt_ff - 20'h00001;
        end
      end
      ST_ALLSTOP: begin
        if (allStopWake) begin
          nxt_mode = ST_RUN;
        end
      end
      ST_HWSTBY: begin
        if (pins.hwStandbyPin) begin
          nxt_mode = ST_RUN;
        end
      end
      default: nxt_mode = ST_RUN;
    endcase
    // reset from any low-power mode except hardware standby returns clocks at once
    if (sysReset && mode_ff != ST_HWSTBY) begin
      nxt_mode = ST_RUN;
    end
    if (!pins.hwStandbyPin) begin
      nxt_mode = ST_HWSTBY;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock divider enable
  always_comb begin
    nxt_divCnt = divCnt_ff + 5'h01;
    if (divCnt_ff >= 5'((1 << div_ff) - 1)) begin
      nxt_divCnt = 5'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_ff <= ST_RUN;
      divReq_ff <= DIV_RESET;
      div_ff <= DIV_RESET;
      selBit_ff <= 1'b0;
      holdBit_ff <= 1'b0;
      sts_ff <= STS_RESET;
      wakeEn_ff <= 16'h0000;
      stopReq_ff <= STOP_RESET;
      stop_ff <= STOP_RESET;
      cnt_ff <= 20'h00000;
      divCnt_ff <= 5'h00;
    end else begin
      mode_ff <= nxt_mode;
      divReq_ff <= nxt_divReq;
      div_ff <= nxt_div;
      selBit_ff <= nxt_selBit;
      holdBit_ff <= nxt_holdBit;
      sts_ff <= nxt_sts;
      wakeEn_ff <= nxt_wakeEn;
      stopReq_ff <= nxt_stopReq;
      stop_ff <= nxt_stop;
      cnt_ff <= nxt_cnt;
      divCnt_ff <= nxt_divCnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  logic stbyOrSettle, allStop;
  assign stbyOrSettle = mode_ff == ST_SWSTBY || mode_ff == ST_SETTLE;
  assign allStop = mode_ff == ST_ALLSTOP;
  assign activeDivide = div_ff;
  assign clockEnable = divCnt_ff == 5'h00 && !stbyOrSettle && mode_ff != ST_HWSTBY;
  assign cpuHalt = mode_ff != ST_RUN;
  assign periphHalt = stbyOrSettle || allStop || mode_ff == ST_HWSTBY;
  assign oscStop = mode_ff == ST_SWSTBY || mode_ff == ST_HWSTBY;
  assign inReset = sysReset || mode_ff == ST_HWSTBY;
  assign interruptStart = (mode_ff == ST_SETTLE && cnt_ff == 20'h00000 && !sysReset && pins.hwStandbyPin)
    || (mode_ff == ST_SLEEP && intWake && !sysReset && pins.hwStandbyPin)
    || (allStop && allStopWake && !sysReset && pins.hwStandbyPin);
  assign busOutFloat = (stbyOrSettle && !holdBit_ff) || allStop || mode_ff == ST_HWSTBY;
  assign ioFloat = mode_ff == ST_HWSTBY;
  assign moduleStopWord = stop_ff;
  // timer8 follows its own stop bit in all-clocks-stop
  assign moduleClockEnable = (stbyOrSettle || mode_ff == ST_HWSTBY) ? 15'h0000 :
    allStop ? {14'h0000, ~stop_ff[TIMER8_POS]} : ~stop_ff[14:0];
  assign serialStateClear = stbyOrSettle || (|stop_ff[3:1]);
  assign modeState = mode_ff;
endmodule

// ### logic/pdm_partner.sv
// far end: drives reset and standby pins in the required order
`timescale 1ns/1ps
module pdm_partner
  import pdm_pkg::*;
#(
  parameter int HOLD = RESET_HOLD_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  pdm_if.host pins,
  // user requests
  input wire logic enterHwStandby,
  input wire logic exitHwStandby,
  input wire logic pulseReset,
  input wire logic [2:0] modePinsIn,
  input wire logic [15:0] irqIn,
  input wire logic nmiIn,
  input wire logic [15:0] irqMaskIn,
  input wire logic [15:0] dtcSourceIn,
  input wire logic cpuMaskIn,
  input wire logic wdtResetIn,
  output logic busy
);
  if (HOLD < 1) begin : g_badHold
    $error("HOLD must be at least one");
  end
  typedef enum logic [3:0] {
    P_IDLE = 4'h1, P_RSTLOW = 4'h2, P_HW_STANDBY_PIN = 4'h4, P_SETTLE = 4'h8
  } pstate_t;
  pstate_t st_ff, nxt_st;
  logic [19:0] cnt_ff, nxt_cnt;
  logic goStby_ff, nxt_goStby;
  logic [2:0] modeHold_ff, nxt_modeHold;

  ////////////////////////////////////////////////////////////////////////
  // sequence: reset low, then standby low; exit in reverse
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_goStby = goStby_ff;
    nxt_modeHold = modeHold_ff;
    unique case (st_ff)
      P_IDLE: begin
        nxt_modeHold = modePinsIn;
        if (enterHwStandby || pulseReset) begin
          nxt_st = P_RSTLOW;
          nxt_goStby = enterHwStandby;
          nxt_cnt = 20'(HOLD);
        end
      end
      P_RSTLOW: begin
        if (cnt_ff != 20'h00000) begin
          nxt_cnt = cnt_ff - 20'h00001;
        end else if (goStby_ff) begin
          nxt_st = P_HW_STANDBY_PIN;
        end else begin
          nxt_st = P_IDLE;
        end
      end
      P_HW_STANDBY_PIN: begin
        if (exitHwStandby) begin
          nxt_st = P_SETTLE;
          nxt_cnt = 20'(HOLD);
        end
      end
      P_SETTLE: begin
        if (cnt_ff != 20'h00000) begin
          nxt_cnt = cnt_ff - 20'h00001;
        end else begin
          nxt_st = P_IDLE;
        end
      end
      default: nxt_st = P_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= P_IDLE;
      cnt_ff <= 20'h00000;
      goStby_ff <= 1'b0;
      modeHold_ff <= 3'h0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      goStby_ff <= nxt_goStby;
      modeHold_ff <= nxt_modeHold;
    end
  end

  assign pins.resetPin = st_ff == P_IDLE;
  assign pins.hwStandbyPin = st_ff != P_HW_STANDBY_PIN;
  assign pins.operatingModePins = modeHold_ff;
  assign pins.ramEnableBit = !(goStby_ff && st_ff != P_IDLE);
  assign pins.watchdogReset = wdtResetIn;
  assign pins.nmi = nmiIn;
  assign pins.irq = irqIn;
  assign pins.irqMasked = irqMaskIn;
  assign pins.irqDtcSource = dtcSourceIn;
  assign pins.cpuIntMasked = cpuMaskIn;
  assign pins.intEnabledPending = nmiIn | (|(irqIn & ~irqMaskIn));
  assign pins.timer8Int = 1'b0;
  assign pins.watchdogInt = 1'b0;
  assign busy = st_ff != P_IDLE;
endmodule

// ### sim/pdm_asserts.sv
// concurrent checks on the controller pins and status
`timescale 1ns/1ps
module pdm_asserts
  import pdm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins and wake lines
  input wire logic resetPin,
  input wire logic hwStandbyPin,
  input wire logic watchdogReset,
  input wire logic nmi,
  input wire logic [15:0] irq,
  input wire logic [15:0] irqMasked,
  input wire logic [15:0] irqDtcSource,
  // device status
  input wire logic [5:0] modeState,
  input wire logic [2:0] activeDivide,
  input wire logic cpuHalt,
  input wire logic periphHalt,
  input wire logic oscStop,
  input wire logic ioFloat,
  input wire logic interruptStart,
  input wire logic [15:0] moduleStopWord,
  input wire logic [14:0] moduleClockEnable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  sequence s_swstby_quiet;
    modeState == ST_SWSTBY && !nmi && resetPin && hwStandbyPin && !watchdogReset
      && ((irq & ~irqMasked & ~irqDtcSource) == 16'h0);
  endsequence
  sequence s_wake_done;
    interruptStart && resetPin && hwStandbyPin && !watchdogReset;
  endsequence
  ////////////////////////////////////////////////////////////////
  a_reset_state: assert property ($rose(rst_n) |-> modeState == ST_RUN && moduleStopWord == 16'h0fff)
    else $error("state after reset wrong");
  a_pin_reset_clears: assert property (!resetPin && hwStandbyPin && modeState != ST_HWSTBY |=>
    activeDivide == 3'h0 && modeState == ST_RUN) else $error("reset pin did not clear division");
  a_hwstby_entry: assert property (!hwStandbyPin |=> modeState == ST_HWSTBY)
    else $error("standby pin low without hardware standby");
  a_hwstby_float: assert property (modeState == ST_HWSTBY |->
    ioFloat && oscStop && periphHalt && moduleClockEnable == 15'h0000)
    else $error("ports not floated in hardware standby");
  a_sleep_halts_cpu: assert property (modeState == ST_SLEEP |-> cpuHalt && !periphHalt)
    else $error("sleep halt levels wrong");
  a_swstby_stops_all: assert property (modeState == ST_SWSTBY |->
    oscStop && cpuHalt && periphHalt && moduleClockEnable == 15'h0000)
    else $error("software standby stop levels wrong");
  a_no_false_wake: assert property (s_swstby_quiet |=> modeState == ST_SWSTBY)
    else $error("software standby left without a wake source");
  a_wake_to_run: assert property (s_wake_done |=> modeState == ST_RUN && !cpuHalt)
    else $error("no return to run after interrupt start");
  a_divide_range: assert property (activeDivide <= DIV_MAX)
    else $error("divide setting out of range");
  a_stop_gates: assert property (modeState == ST_RUN || modeState == ST_SLEEP || modeState == ST_ALLSTOP |->
    moduleClockEnable == ~moduleStopWord[14:0]) else $error("module clock gates disagree with stop word");
endmodule

// ### sim/test_power_down_mode_controller.sv
// testbench for the power-down mode controller and its pin partner
`timescale 1ns/1ps
module test_power_down_mode_controller
  import pdm_pkg::*;
();
  logic clk, rst_n, divWr, stbyWr, selBit, holdBit, wakeWr, stopWr, sleepExec, busBusy;
  logic enterHw, exitHw, pulseRst, nmiIn, clockEnable, cpuHalt, periphHalt, oscStop, inReset;
  logic interruptStart, busOutFloat, ioFloat, serialStateClear, pBusy;
  logic [2:0] divIn, activeDivide;
  logic [3:0] stsIn;
  logic [15:0] stopIn, moduleStopWord;
  logic cpuMask, wdtRst;
  logic [15:0] wakeEnIn, irqIn, irqMaskIn, dtcIn;
  logic [14:0] moduleClockEnable;
  logic [5:0] modeState;
  int failures = 0;
  int cmpCount = 0;
  int n;
  pdm_if pins ();
  power_down_mode_controller #(.RESET_HOLD(2)) power_down_mode_controller_inst (.clk(clk), .rst_n(rst_n),
    .pins(pins), .clockDivideWr(divWr), .clockDivideField(divIn), .standbyCtrlWr(stbyWr),
    .standbySelectBit(selBit), .standbyOutputHoldBit(holdBit), .settlingTimeField(stsIn),
    .standbyWakeEnableWr(wakeWr), .standbyWakeEnableBit(wakeEnIn), .moduleStopWr(stopWr),
    .moduleStopWordIn(stopIn), .sleepExec(sleepExec), .busBusy(busBusy), .activeDivide(activeDivide),
    .clockEnable(clockEnable), .cpuHalt(cpuHalt), .periphHalt(periphHalt), .oscStop(oscStop),
    .inReset(inReset), .interruptStart(interruptStart), .busOutFloat(busOutFloat), .ioFloat(ioFloat),
    .moduleStopWord(moduleStopWord), .moduleClockEnable(moduleClockEnable),
    .serialStateClear(serialStateClear), .modeState(modeState));
  pdm_partner #(.HOLD(2)) pdm_partner_inst (.clk(clk), .rst_n(rst_n), .pins(pins), .enterHwStandby(enterHw),
    .exitHwStandby(exitHw), .pulseReset(pulseRst), .modePinsIn(3'h0), .irqIn(irqIn), .nmiIn(nmiIn),
    .irqMaskIn(irqMaskIn), .dtcSourceIn(dtcIn), .cpuMaskIn(cpuMask), .wdtResetIn(wdtRst), .busy(pBusy));
  pdm_asserts pdm_asserts_inst (.clk(clk), .rst_n(rst_n), .resetPin(pins.resetPin),
    .hwStandbyPin(pins.hwStandbyPin), .watchdogReset(pins.watchdogReset), .nmi(pins.nmi), .irq(pins.irq),
    .irqMasked(pins.irqMasked), .irqDtcSource(pins.irqDtcSource), .modeState(modeState),
    .activeDivide(activeDivide), .cpuHalt(cpuHalt), .periphHalt(periphHalt), .oscStop(oscStop),
    .ioFloat(ioFloat), .interruptStart(interruptStart), .moduleStopWord(moduleStopWord),
    .moduleClockEnable(moduleClockEnable));
  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int k = 1);
    repeat (k) @(negedge clk);
  endtask
  task automatic waitMode(input logic [5:0] m, input int lim);
    n = 0;
    while (modeState !== m && n < lim) begin
      tick();
      n++;
    end
    check("mode", modeState, m);
  endtask
  task automatic waitIdle();
    tick(2);
    n = 0;
    while (pBusy !== 1'b0 && n < 200) begin
      tick();
      n++;
    end
    check("partner idle", pBusy, 1'b0);
  endtask
  task automatic wrDiv(input logic [2:0] c);
    divIn = c;
    divWr = 1'b1;
    tick();
    divWr = 1'b0;
    tick();
  endtask
  task automatic wrStby(input logic s, input logic h, input logic [3:0] t);
    selBit = s;
    holdBit = h;
    stsIn = t;
    stbyWr = 1'b1;
    tick();
    stbyWr = 1'b0;
    tick();
  endtask
  task automatic wrStop(input logic [15:0] w);
    stopIn = w;
    stopWr = 1'b1;
    tick();
    stopWr = 1'b0;
    tick(3);
  endtask
  task automatic doSleep();
    sleepExec = 1'b1;
    tick();
    sleepExec = 1'b0;
  endtask
  task automatic wrWake(input logic [15:0] w);
    wakeEnIn = w;
    wakeWr = 1'b1;
    tick();
    wakeWr = 1'b0;
    tick();
  endtask
  // counts settle cycles from the first one up to the interrupt start
  task automatic countSettle();
    n = 1;
    while (interruptStart !== 1'b1 && n < 600) begin
      tick();
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
  initial begin
    {rst_n, divWr, stbyWr, selBit, holdBit, wakeWr, stopWr, sleepExec, busBusy} = '0;
    {enterHw, exitHw, pulseRst, nmiIn, divIn, stsIn, stopIn} = '0;
    {cpuMask, wdtRst, wakeEnIn, irqIn, irqMaskIn, dtcIn} = '0;
    tick(4);
    rst_n = 1'b1;
    tick();
    check("mode", modeState, ST_RUN);
    check("stop word", moduleStopWord, 16'h0fff);
    check("module clocks", moduleClockEnable, 15'h7000);
    // division held off while a bus cycle runs
    busBusy = 1'b1;
    wrDiv(3'h3);
    tick(3);
    check("divide busy", activeDivide, 3'h0);
    busBusy = 1'b0;
    tick(3);
    check("divide", activeDivide, 3'h3);
    n = 0;
    repeat (32) begin
      tick();
      n += (clockEnable === 1'b1);
    end
    check("clock pulses", n, 4);
    wrDiv(3'h7);
    tick(3);
    check("divide code 7", activeDivide, 3'h3);
    wrDiv(3'h0);
    tick(3);
    check("divide zero", activeDivide, 3'h0);
    // sleep, then reset pin
    wrDiv(3'h4);
    tick(3);
    wrStby(1'b0, 1'b0, 4'h5);
    doSleep();
    waitMode(ST_SLEEP, 4);
    check("sleep cpu", cpuHalt, 1'b1);
    pulseRst = 1'b1;
    tick();
    pulseRst = 1'b0;
    check("in reset", inReset, 1'b1);
    waitIdle();
    waitMode(ST_RUN, 40);
    check("divide reset", activeDivide, 3'h0);
    check("reset released", inReset, 1'b0);
    // software standby, nmi wake, 64 state settle
    wrDiv(3'h2);
    tick(3);
    wrStby(1'b1, 1'b1, 4'h5);
    doSleep();
    waitMode(ST_SWSTBY, 4);
    check("osc stop", oscStop, 1'b1);
    check("serial clear", serialStateClear, 1'b1);
    check("bus hold", busOutFloat, 1'b0);
    tick(5);
    check("no wake", modeState, ST_SWSTBY);
    nmiIn = 1'b1;
    waitMode(ST_SETTLE, 8);
    nmiIn = 1'b0;
    countSettle();
    check("settle states", n, 64);
    tick();
    check("after settle", modeState, ST_RUN);
    check("divide kept", activeDivide, 3'h2);
    // irq wake needs its enable and no mask or dtc claim; code 3 is refused
    wrWake(16'h0002);
    wrStby(1'b1, 1'b0, 4'h3);
    doSleep();
    waitMode(ST_SWSTBY, 4);
    check("bus float", busOutFloat, 1'b1);
    irqIn = 16'h0001;
    tick(3);
    check("irq not enabled", modeState, ST_SWSTBY);
    irqIn = 16'h0002;
    irqMaskIn = 16'h0002;
    tick(3);
    check("irq masked", modeState, ST_SWSTBY);
    irqMaskIn = 16'h0000;
    dtcIn = 16'h0002;
    tick(3);
    check("irq dtc source", modeState, ST_SWSTBY);
    dtcIn = 16'h0000;
    waitMode(ST_SETTLE, 4);
    irqIn = 16'h0000;
    countSettle();
    check("refused code kept", n, 64);
    tick();
    check("irq wake run", modeState, ST_RUN);
    // sleep: cpu mask holds it, nmi still ends it, unmasked irq ends it
    wrStby(1'b0, 1'b0, 4'h5);
    doSleep();
    waitMode(ST_SLEEP, 4);
    cpuMask = 1'b1;
    irqIn = 16'h0001;
    tick(3);
    check("masked sleep", modeState, ST_SLEEP);
    nmiIn = 1'b1;
    waitMode(ST_RUN, 4);
    check("sleep divide kept", activeDivide, 3'h2);
    {cpuMask, nmiIn} = '0;
    doSleep();
    waitMode(ST_SLEEP, 2);
    waitMode(ST_RUN, 2);
    irqIn = 16'h0000;
    // watchdog reset clears division
    wdtRst = 1'b1;
    tick();
    wdtRst = 1'b0;
    tick();
    check("watchdog clears divide", activeDivide, 3'h0);
    // module stop and all-clocks-stop
    wrStop(16'h0001);
    check("timer gate", moduleClockEnable, 15'h7ffe);
    check("serial kept", serialStateClear, 1'b0);
    wrStop(STOP_ALL);
    wrStby(1'b0, 1'b0, 4'h5);
    doSleep();
    waitMode(ST_ALLSTOP, 4);
    check("all stop gates", moduleClockEnable, 15'h0000);
    nmiIn = 1'b1;
    waitMode(ST_RUN, 100);
    nmiIn = 1'b0;
    wrStop(STOP_ALL_BUT_T8);
    doSleep();
    waitMode(ST_ALLSTOP, 4);
    check("timer runs", moduleClockEnable, 15'h0001);
    nmiIn = 1'b1;
    waitMode(ST_RUN, 4);
    nmiIn = 1'b0;
    // hardware standby through the partner
    enterHw = 1'b1;
    tick();
    enterHw = 1'b0;
    waitMode(ST_HWSTBY, 40);
    check("io float", ioFloat, 1'b1);
    check("hw reset", inReset, 1'b1);
    check("hw gates", moduleClockEnable, 15'h0000);
    check("ram enable", pins.ramEnableBit, 1'b0);
    check("mode pins", pins.operatingModePins, 3'h0);
    exitHw = 1'b1;
    tick();
    exitHw = 1'b0;
    waitIdle();
    waitMode(ST_RUN, 40);
    check("stop word again", moduleStopWord, 16'h0fff);
    report_and_stop();
  end
endmodule
